// ===== rtl/key_press.sv
`timescale 1ns/1ps
`default_nettype none

// synchronises, debounces and edge-detects one key pin
module key_press #(
  parameter int unsigned STABLE_CYCLES = 1
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic nrst_in,
  // key pin, high while pressed
  input  wire logic key_in,
  // outputs
  output logic      level_out,
  output logic      press_out
);

  localparam int unsigned CW = (STABLE_CYCLES > 1) ? $clog2(STABLE_CYCLES + 1) : 1;
  localparam logic [CW-1:0] CNT_LAST = CW'(STABLE_CYCLES - 1);

  logic          sync_a;
  logic          sync_b;
  logic [CW-1:0] stable_cnt;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= key_in;
      sync_b <= sync_a;
    end
  end

  // level changes only after the pin held steady long enough
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      stable_cnt <= '0;
      level_out  <= 1'b0;
    end else if (sync_b == level_out) begin
      stable_cnt <= '0;
    end else if (stable_cnt == CNT_LAST) begin
      stable_cnt <= '0;
      level_out  <= sync_b;
    end else begin
      stable_cnt <= stable_cnt + CW'(1);
    end
  end

  // one pulse on the accepted press edge
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      press_out <= 1'b0;
    end else begin
      press_out <= (sync_b != level_out) && (stable_cnt == CNT_LAST) && sync_b;
    end
  end

endmodule : key_press

`default_nettype wire

// ===== rtl/panel_pkg.sv
package panel_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned SETTLE_MS       = 100;
  localparam int unsigned DEBOUNCE_MS     = 10;
  localparam int unsigned SETTLE_CYCLES   = (SETTLE_MS * (CLK_HZ / 1000) > 0) ?
                                            SETTLE_MS * (CLK_HZ / 1000) : 1;
  localparam int unsigned DEBOUNCE_CYCLES = (DEBOUNCE_MS * (CLK_HZ / 1000) > 0) ?
                                            DEBOUNCE_MS * (CLK_HZ / 1000) : 1;

  // threshold defaults
  localparam logic [15:0] SPEED_MATCH_DEFAULT   = 16'h000a;  // 10 rpm
  localparam logic [15:0] POSITION_DONE_DEFAULT = 16'h000a;  // 10 pulses
  localparam logic [15:0] ROTATION_DEFAULT      = 16'h0014;  // 20 rpm
  localparam logic [15:0] TORQUE_LEVEL_DEFAULT  = 16'h000a;  // 10 % rated

  // threshold select codes
  localparam logic [1:0] THR_SPEED_MATCH   = 2'h0;
  localparam logic [1:0] THR_POSITION_DONE = 2'h1;
  localparam logic [1:0] THR_ROTATION      = 2'h2;
  localparam logic [1:0] THR_TORQUE_LEVEL  = 2'h3;

  // bit data segment positions
  localparam int unsigned SEG_MATCH    = 0;
  localparam int unsigned SEG_SERVOOFF = 1;
  localparam int unsigned SEG_CTRLPWR  = 2;
  localparam int unsigned SEG_REF      = 3;
  localparam int unsigned SEG_TORQ_CLR = 4;
  localparam int unsigned SEG_MAINPWR  = 5;
  localparam int unsigned SEG_ROTATE   = 6;

  localparam int unsigned EDIT_DIGITS = 5;
  localparam logic [3:0]  BCD_MAX     = 4'h9;

  typedef enum logic [1:0] {
    CTRL_SPEED    = 2'b00,
    CTRL_TORQUE   = 2'b01,
    CTRL_POSITION = 2'b10
  } ctrl_mode_t;

  typedef enum logic [1:0] {
    MODE_STATUS  = 2'b00,
    MODE_PARAM   = 2'b01,
    MODE_UTILITY = 2'b10,
    MODE_MONITOR = 2'b11
  } basic_mode_t;

  typedef enum logic [3:0] {
    CODE_INIT_FAIL = 4'b0000,
    CODE_SERVO_OFF = 4'b0001,
    CODE_READY     = 4'b0010,
    CODE_RUN       = 4'b0011,
    CODE_QSTOP     = 4'b0100,
    CODE_ALARM     = 4'b0101,
    CODE_SAFE      = 4'b0110,
    CODE_FWD_PROH  = 4'b0111,
    CODE_REV_PROH  = 4'b1000,
    CODE_OVERTRAV  = 4'b1001,
    CODE_ALARM_NUM = 4'b1010
  } state_code_t;

endpackage : panel_pkg

// ===== rtl/panel_status_display.sv
`timescale 1ns/1ps
`default_nettype none

module panel_status_display
  import panel_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES_P   = panel_pkg::SETTLE_CYCLES,
  parameter int unsigned DEBOUNCE_CYCLES_P = panel_pkg::DEBOUNCE_CYCLES
) (
  // clock and reset
  input  wire logic                     clk_in,
  input  wire logic                     nrst_in,
  // key pins, high while pressed
  input  wire logic                     key_mode_in,
  input  wire logic                     key_up_in,
  input  wire logic                     key_down_in,
  input  wire logic                     key_data_in,
  // drive control state
  input  wire panel_pkg::ctrl_mode_t    ctrl_mode_in,
  input  wire logic signed [15:0]       motor_speed_in,
  input  wire logic signed [15:0]       speed_ref_in,
  input  wire logic signed [15:0]       torque_ref_in,
  input  wire logic signed [31:0]       position_error_in,
  input  wire logic                     servo_on_in,
  input  wire logic                     ctrl_power_in,
  input  wire logic                     main_power_ok_in,
  input  wire logic                     ref_pulse_active_in,
  input  wire logic                     dev_clear_in,
  // drive operating state
  input  wire logic                     init_fail_in,
  input  wire logic                     drive_ready_in,
  input  wire logic                     quick_stop_in,
  input  wire logic                     alarm_in,
  input  wire logic                     safe_in,
  input  wire logic                     fwd_prohibit_in,
  input  wire logic                     rev_prohibit_in,
  // threshold loading
  input  wire logic                     thr_wr_in,
  input  wire logic [1:0]               thr_sel_in,
  input  wire logic [15:0]              thr_data_in,
  // panel state
  output logic                          panel_ready_out,
  output panel_pkg::basic_mode_t        basic_mode_out,
  output logic [6:0]                    bit_data_out,
  output panel_pkg::state_code_t        state_code_out,
  output logic                          speed_match_flag_out,
  output logic                          position_done_flag_out,
  output logic                          rotation_detect_flag_out,
  // selection and editing
  output logic [7:0]                    select_index_out,
  output logic                          value_open_out,
  output logic [19:0]                   edit_value_out,
  output logic [2:0]                    edit_digit_out,
  // alarm clear request
  output logic                          alarm_clear_out
);
  import panel_pkg::*;

  localparam logic [2:0]  DIGIT_LAST = 3'(EDIT_DIGITS - 1);
  localparam int unsigned SW = (SETTLE_CYCLES_P > 1) ? $clog2(SETTLE_CYCLES_P + 1) : 1;
  localparam logic [SW-1:0] SETTLE_LAST = SW'(SETTLE_CYCLES_P - 1);

  logic          press_mode;
  logic          press_up;
  logic          press_down;
  logic          press_data;
  logic [SW-1:0] settle_cnt;
  logic [15:0]   speed_match_threshold;
  logic [15:0]   position_done_threshold;
  logic [15:0]   rotation_detect_threshold;
  logic [15:0]   torque_level;
  logic          alarm_num_view;
  logic [6:0]    next_bits;
  state_code_t   next_code;
  logic [16:0]   speed_err_mag;
  logic [16:0]   speed_mag;
  logic [16:0]   ref_mag;
  logic [16:0]   torque_mag;
  logic [31:0]   pos_err_mag;
  logic [3:0]    cur_nibble;

  function automatic logic [16:0] mag17(input logic signed [16:0] v);
    return v[16] ? 17'(-v) : 17'(v);
  endfunction : mag17

  key_press #(.STABLE_CYCLES(DEBOUNCE_CYCLES_P)) u_key_mode (.clk_in(clk_in), .nrst_in(nrst_in),
    .key_in(key_mode_in), .level_out(), .press_out(press_mode));
  key_press #(.STABLE_CYCLES(DEBOUNCE_CYCLES_P)) u_key_up (.clk_in(clk_in), .nrst_in(nrst_in),
    .key_in(key_up_in), .level_out(), .press_out(press_up));
  key_press #(.STABLE_CYCLES(DEBOUNCE_CYCLES_P)) u_key_down (.clk_in(clk_in), .nrst_in(nrst_in),
    .key_in(key_down_in), .level_out(), .press_out(press_down));
  key_press #(.STABLE_CYCLES(DEBOUNCE_CYCLES_P)) u_key_data (.clk_in(clk_in), .nrst_in(nrst_in),
    .key_in(key_data_in), .level_out(), .press_out(press_data));

  // power-up settling
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      settle_cnt      <= '0;
      panel_ready_out <= 1'b0;
    end else if (!panel_ready_out) begin
      if (settle_cnt == SETTLE_LAST) begin
        panel_ready_out <= 1'b1;
      end else begin
        settle_cnt <= settle_cnt + SW'(1);
      end
    end
  end

  // thresholds, loaded by the drive's parameter logic
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      speed_match_threshold     <= SPEED_MATCH_DEFAULT;
      position_done_threshold   <= POSITION_DONE_DEFAULT;
      rotation_detect_threshold <= ROTATION_DEFAULT;
      torque_level              <= TORQUE_LEVEL_DEFAULT;
    end else if (thr_wr_in) begin
      unique case (thr_sel_in)
        THR_SPEED_MATCH:   speed_match_threshold     <= thr_data_in;
        THR_POSITION_DONE: position_done_threshold   <= thr_data_in;
        THR_ROTATION:      rotation_detect_threshold <= thr_data_in;
        THR_TORQUE_LEVEL:  torque_level              <= thr_data_in;
      endcase
    end
  end

  // basic mode; held in status until settled
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      basic_mode_out <= MODE_STATUS;
    end else if (panel_ready_out && press_mode) begin
      basic_mode_out <= basic_mode_t'(basic_mode_out + 2'h1);
    end
  end

  // selection, value open and digit shifting
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      select_index_out <= 8'h00;
      value_open_out   <= 1'b0;
      edit_digit_out   <= 3'h0;
    end else if (panel_ready_out) begin
      if (press_mode) begin
        value_open_out <= 1'b0;
        edit_digit_out <= 3'h0;
      end else if (basic_mode_out != MODE_STATUS) begin
        if (press_data) begin
          value_open_out <= 1'b1;
          if (value_open_out) begin
            edit_digit_out <= (edit_digit_out == DIGIT_LAST) ? 3'h0 :
                              edit_digit_out + 3'h1;
          end
        end else if (!value_open_out && press_up) begin
          select_index_out <= select_index_out + 8'h01;
        end else if (!value_open_out && press_down) begin
          select_index_out <= select_index_out - 8'h01;
        end
      end
    end
  end

  assign cur_nibble = edit_value_out[4*edit_digit_out +: 4];

  // decimal digit editing, each digit wraps 0..9
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      edit_value_out <= 20'h00000;
    end else if (panel_ready_out && value_open_out && !press_mode && !press_data &&
                 basic_mode_out != MODE_STATUS) begin
      if (press_up) begin
        edit_value_out[4*edit_digit_out +: 4] <=
          (cur_nibble >= BCD_MAX) ? 4'h0 : cur_nibble + 4'h1;
      end else if (press_down) begin
        edit_value_out[4*edit_digit_out +: 4] <=
          (cur_nibble == 4'h0) ? BCD_MAX : cur_nibble - 4'h1;
      end
    end
  end

  // alarm number view and alarm clear request
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      alarm_num_view  <= 1'b0;
      alarm_clear_out <= 1'b0;
    end else begin
      alarm_clear_out <= panel_ready_out && basic_mode_out == MODE_STATUS && alarm_in &&
                         press_data && !press_mode;
      if (!alarm_in) begin
        alarm_num_view <= 1'b0;
      end else if (basic_mode_out == MODE_STATUS && (press_up || press_down)) begin
        alarm_num_view <= !alarm_num_view;
      end
    end
  end

  // magnitudes for the comparisons
  always_comb begin
    speed_err_mag = mag17(17'(motor_speed_in) - 17'(speed_ref_in));
    speed_mag     = mag17(17'(motor_speed_in));
    ref_mag       = mag17(17'(speed_ref_in));
    torque_mag    = mag17(17'(torque_ref_in));
    pos_err_mag   = position_error_in[31] ? 32'(-position_error_in) : 32'(position_error_in);
  end

  // bit data segments
  always_comb begin
    next_bits = 7'h00;
    next_bits[SEG_SERVOOFF] = !servo_on_in;
    next_bits[SEG_CTRLPWR]  = ctrl_power_in;
    next_bits[SEG_MAINPWR]  = main_power_ok_in;
    next_bits[SEG_ROTATE]   = speed_mag > {1'b0, rotation_detect_threshold};
    if (ctrl_mode_in == CTRL_POSITION) begin
      next_bits[SEG_MATCH]    = pos_err_mag < {16'h0000, position_done_threshold};
      next_bits[SEG_REF]      = ref_pulse_active_in;
      next_bits[SEG_TORQ_CLR] = dev_clear_in;
    end else begin
      next_bits[SEG_MATCH]    = (ctrl_mode_in == CTRL_TORQUE) ||
                                speed_err_mag <= {1'b0, speed_match_threshold};
      next_bits[SEG_REF]      = ref_mag > {1'b0, rotation_detect_threshold};
      next_bits[SEG_TORQ_CLR] = torque_mag > {1'b0, torque_level};
    end
  end

  // state code priority
  always_comb begin
    if (init_fail_in) next_code = CODE_INIT_FAIL;
    else if (alarm_in) next_code = alarm_num_view ? CODE_ALARM_NUM : CODE_ALARM;
    else if (safe_in) next_code = CODE_SAFE;
    else if (quick_stop_in) next_code = CODE_QSTOP;
    else if (fwd_prohibit_in && rev_prohibit_in) next_code = CODE_OVERTRAV;
    else if (fwd_prohibit_in) next_code = CODE_FWD_PROH;
    else if (rev_prohibit_in) next_code = CODE_REV_PROH;
    else if (servo_on_in) next_code = CODE_RUN;
    else if (drive_ready_in) next_code = CODE_READY;
    else next_code = CODE_SERVO_OFF;
  end

  // registered display data; bit data blank until settled, state code and flags not gated
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      bit_data_out             <= 7'h00;
      state_code_out           <= CODE_SERVO_OFF;
      speed_match_flag_out     <= 1'b0;
      position_done_flag_out   <= 1'b0;
      rotation_detect_flag_out <= 1'b0;
    end else begin
      bit_data_out   <= panel_ready_out ? next_bits : 7'h00;
      state_code_out <= next_code;
      speed_match_flag_out     <= ctrl_mode_in != CTRL_POSITION && next_bits[SEG_MATCH];
      position_done_flag_out   <= ctrl_mode_in == CTRL_POSITION && next_bits[SEG_MATCH];
      rotation_detect_flag_out <= next_bits[SEG_ROTATE];
    end
  end

  property p_mode_step;
    @(posedge clk_in) disable iff (!nrst_in)
    (panel_ready_out && press_mode) |=> basic_mode_out == basic_mode_t'($past(basic_mode_out) + 2'h1);
  endproperty
  a_mode_step: assert property (p_mode_step) else $error("mode did not advance");
  property p_select_up;
    @(posedge clk_in) disable iff (!nrst_in)
    (panel_ready_out && press_up && !press_mode && !press_data && !value_open_out &&
     basic_mode_out != MODE_STATUS) |=> select_index_out == $past(select_index_out) + 8'h01;
  endproperty
  a_select_up: assert property (p_select_up) else $error("select not incremented");
  property p_select_down;
    @(posedge clk_in) disable iff (!nrst_in)
    (panel_ready_out && press_down && !press_up && !press_mode && !press_data &&
     !value_open_out && basic_mode_out != MODE_STATUS)
      |=> select_index_out == $past(select_index_out) - 8'h01;
  endproperty
  a_select_down: assert property (p_select_down) else $error("select not decremented");
  property p_digit_shift;
    @(posedge clk_in) disable iff (!nrst_in)
    (panel_ready_out && value_open_out && press_data && !press_mode &&
     basic_mode_out != MODE_STATUS && edit_digit_out != DIGIT_LAST)
      |=> edit_digit_out == $past(edit_digit_out) + 3'h1;
  endproperty
  a_digit_shift: assert property (p_digit_shift) else $error("digit not shifted");
  property p_settle_mode;
    @(posedge clk_in) disable iff (!nrst_in)
    $rose(panel_ready_out) |-> basic_mode_out == MODE_STATUS;
  endproperty
  a_settle_mode: assert property (p_settle_mode) else $error("not in status after settle");
  property p_torque_match;
    @(posedge clk_in) disable iff (!nrst_in)
    (panel_ready_out && ctrl_mode_in == CTRL_TORQUE) |=> bit_data_out[SEG_MATCH];
  endproperty
  a_torque_match: assert property (p_torque_match) else $error("torque match unlit");
  property p_servo_off_seg;
    @(posedge clk_in) disable iff (!nrst_in)
    panel_ready_out ##1 panel_ready_out |-> bit_data_out[SEG_SERVOOFF] == !$past(servo_on_in);
  endproperty
  a_servo_off_seg: assert property (p_servo_off_seg) else $error("servo off segment wrong");
  property p_alarm_code;
    @(posedge clk_in) disable iff (!nrst_in)
    (alarm_in && !init_fail_in) |=> state_code_out inside {CODE_ALARM, CODE_ALARM_NUM};
  endproperty
  a_alarm_code: assert property (p_alarm_code) else $error("alarm code missing");
  property p_alarm_clear;
    @(posedge clk_in) disable iff (!nrst_in)
    (panel_ready_out && basic_mode_out == MODE_STATUS && alarm_in && press_data && !press_mode)
      |=> alarm_clear_out ##1 !alarm_clear_out;
  endproperty
  a_alarm_clear: assert property (p_alarm_clear) else $error("alarm clear not one pulse");
  c_mode_wrap: cover property (@(posedge clk_in) disable iff (!nrst_in)
    basic_mode_out == MODE_MONITOR ##[1:1000] basic_mode_out == MODE_STATUS);
  c_edit: cover property (@(posedge clk_in) disable iff (!nrst_in)
    value_open_out && edit_digit_out == DIGIT_LAST);
  c_clear: cover property (@(posedge clk_in) disable iff (!nrst_in) alarm_clear_out);

endmodule : panel_status_display

`default_nettype wire

// ===== test/operator_keys.sv
`timescale 1ns/1ps
`default_nettype none

// operator at the panel: presses with contact bounce on both edges
module operator_keys #(
  parameter int unsigned DEB = 4
) (
  // clock to pace the hand
  input  wire logic       clk_in,
  // key pins: mode, up, down, data
  output logic      [3:0] keys_out
);
  initial keys_out = 4'h0;

  // bounce shorter than debounce, then a firm hold
  task automatic press(input int k, input int bounces);
    int i;
    for (i = 0; i < bounces; i++) begin
      @(negedge clk_in) keys_out[k] = 1'b1;
      @(negedge clk_in) keys_out[k] = 1'b0;
    end
    @(negedge clk_in) keys_out[k] = 1'b1;
    repeat (DEB + 10) @(negedge clk_in);
    keys_out[k] = 1'b0;
    @(negedge clk_in) keys_out[k] = 1'b1;
    @(negedge clk_in) keys_out[k] = 1'b0;
    repeat (DEB + 10) @(negedge clk_in);
  endtask : press

  // a touch too short to count
  task automatic glitch(input int k);
    @(negedge clk_in) keys_out[k] = 1'b1;
    repeat (2) @(negedge clk_in);
    keys_out[k] = 1'b0;
    repeat (DEB + 10) @(negedge clk_in);
  endtask : glitch
endmodule : operator_keys

`default_nettype wire

// ===== test/panel_status_display_tb.sv
`timescale 1ns/1ps
`default_nettype none

module panel_status_display_tb;
  import panel_pkg::*;
  logic clk = 0, nrst = 0, son = 0, cpw = 0, mpok = 0, rpa = 0, dclr = 0;
  logic ifail = 0, drdy = 0, qstop = 0, alm = 0, safe = 0, fwd = 0, rev = 0, thr_wr = 0;
  logic [1:0] thr_sel = 0;
  logic [15:0] thr_data = 0;
  logic signed [15:0] ms = 0, sr = 0, tq = 0;
  logic signed [31:0] perr = 0;
  ctrl_mode_t ctrl = CTRL_SPEED;
  wire [3:0] keys;
  logic rdy, vopen, aclr, smf, pdf, rdf;
  logic [2:0] fl;
  basic_mode_t bmode;
  state_code_t code;
  logic [6:0] bits, eb;
  logic [7:0] sel;
  logic [19:0] ev, v0;
  logic [2:0] dig;
  logic [31:0] seed = 32'hab7429b8, r, r2;
  int thr[4] = '{10, 10, 20, 10};
  int n_fail = 0, tests_run = 0, n_clr = 0, i;

  always #25 clk = ~clk;
  always @(negedge clk) if (aclr === 1'b1) n_clr++;

  operator_keys #(.DEB(4)) op (.clk_in(clk), .keys_out(keys));
  panel_status_display #(.SETTLE_CYCLES_P(8), .DEBOUNCE_CYCLES_P(4)) DUT (
    .clk_in(clk), .nrst_in(nrst), .key_mode_in(keys[0]), .key_up_in(keys[1]),
    .key_down_in(keys[2]), .key_data_in(keys[3]), .ctrl_mode_in(ctrl),
    .motor_speed_in(ms), .speed_ref_in(sr), .torque_ref_in(tq), .position_error_in(perr),
    .servo_on_in(son), .ctrl_power_in(cpw), .main_power_ok_in(mpok),
    .ref_pulse_active_in(rpa), .dev_clear_in(dclr), .init_fail_in(ifail),
    .drive_ready_in(drdy), .quick_stop_in(qstop), .alarm_in(alm), .safe_in(safe),
    .fwd_prohibit_in(fwd), .rev_prohibit_in(rev), .thr_wr_in(thr_wr),
    .thr_sel_in(thr_sel), .thr_data_in(thr_data), .panel_ready_out(rdy),
    .basic_mode_out(bmode), .bit_data_out(bits), .state_code_out(code),
    .speed_match_flag_out(smf), .position_done_flag_out(pdf), .rotation_detect_flag_out(rdf),
    .select_index_out(sel), .value_open_out(vopen), .edit_value_out(ev),
    .edit_digit_out(dig), .alarm_clear_out(aclr));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic int absv(input int v);
    return (v < 0) ? -v : v;
  endfunction : absv

  function automatic logic [6:0] exp_bits();
    logic pos;
    pos = (ctrl == CTRL_POSITION);
    exp_bits[0] = (ctrl == CTRL_TORQUE) ? 1'b1 : pos ? (absv(perr) < thr[1]) :
                  (absv(int'(ms) - int'(sr)) <= thr[0]);
    exp_bits[1] = !son;
    exp_bits[2] = cpw;
    exp_bits[3] = pos ? rpa : (absv(sr) > thr[2]);
    exp_bits[4] = pos ? dclr : (absv(tq) > thr[3]);
    exp_bits[5] = mpok;
    exp_bits[6] = absv(ms) > thr[2];
  endfunction : exp_bits

  function automatic state_code_t exp_code();
    if (ifail) return CODE_INIT_FAIL;
    if (alm) return CODE_ALARM;
    if (safe) return CODE_SAFE;
    if (qstop) return CODE_QSTOP;
    if (fwd && rev) return CODE_OVERTRAV;
    if (fwd) return CODE_FWD_PROH;
    if (rev) return CODE_REV_PROH;
    if (son) return CODE_RUN;
    if (drdy) return CODE_READY;
    return CODE_SERVO_OFF;
  endfunction : exp_code

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  initial begin
    #1500000;
    n_fail++;
    end_sim();
  end

  initial begin
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    chk(rdy, 0);
    chk(bits, 0);
    chk(code, CODE_SERVO_OFF);
    repeat (8) @(negedge clk);
    chk(rdy, 1);
    chk(bmode, MODE_STATUS);
    chk(bits[1], 1);
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      thr[i] = xs() % 41;
      thr_wr = 1'b1;
      thr_sel = i[1:0];
      thr_data = 16'(thr[i]);
      @(negedge clk);
    end
    thr_wr = 1'b0;
    for (i = 0; i < 200; i++) begin
      r = xs();
      r2 = xs();
      ctrl = ctrl_mode_t'(r[1:0]);
      ms = {{9{r[8]}}, r[8:2]};
      sr = {{9{r[15]}}, r[15:9]};
      tq = {{9{r[22]}}, r[22:16]};
      perr = {{25{r2[6]}}, r2[6:0]};
      {son, cpw, mpok, rpa, dclr, drdy} = r[28:23];
      ifail = &r2[9:7];
      alm = &r2[11:10];
      qstop = &r2[13:12];
      safe = &r2[15:14];
      fwd = r2[16];
      rev = r2[17];
      @(negedge clk);
      eb = exp_bits();
      fl = {ctrl != CTRL_POSITION && eb[0], ctrl == CTRL_POSITION && eb[0], eb[6]};
      chk(bits, eb);
      chk({smf, pdf, rdf}, fl);
      chk(code, exp_code());
    end
    {ifail, qstop, safe, fwd, rev, son, drdy} = '0;
    $display("test status done");
    alm = 1'b1;
    @(negedge clk);
    chk(code, CODE_ALARM);
    op.press(3, 2);
    chk(n_clr, 1);
    op.press(1, 0);
    chk(code, CODE_ALARM_NUM);
    op.press(2, 0);
    chk(code, CODE_ALARM);
    alm = 1'b0;
    op.press(3, 0);
    chk(n_clr, 1);
    $display("test alarm done");
    for (i = 1; i <= 4; i++) begin
      op.press(0, 1);
      chk(bmode, i % 4);
    end
    op.press(0, 0);
    chk(sel, 0);
    op.press(1, 1);
    op.press(1, 0);
    chk(sel, 2);
    op.press(2, 2);
    chk(sel, 1);
    op.press(3, 1);
    chk(vopen, 1);
    v0 = 20'h00000;
    op.press(1, 0);
    v0[3:0] = (v0[3:0] == 4'h9) ? 4'h0 : v0[3:0] + 4'h1;
    chk(ev, v0);
    op.press(3, 0);
    chk(dig, 1);
    op.press(2, 1);
    v0[7:4] = (v0[7:4] == 4'h0) ? 4'h9 : v0[7:4] - 4'h1;
    chk(ev, v0);
    for (i = 0; i < 4; i++) op.press(3, 0);
    chk(dig, 0);
    op.press(0, 0);
    chk(bmode, MODE_UTILITY);
    chk(vopen, 0);
    op.glitch(0);
    chk(bmode, MODE_UTILITY);
    $display("test keys done");
    end_sim();
  end
endmodule : panel_status_display_tb

`default_nettype wire
